/* File: mac_host_model.sv */
// Register bus host that runs AXI4-Lite transfers
`timescale 1ns/1ps
module mac_host_model
   import mac_pkg::*;
(
   input  wire logic         mclk,
   output logic [ADDR_W-1:0] awaddr,
   output logic              awvalid,
   input  wire logic         awready,
   output logic [31:0]       wdata,
   output logic              wvalid,
   input  wire logic         wready,
   input  wire logic         bvalid,
   output logic              bready,
   output logic [ADDR_W-1:0] araddr,
   output logic              arvalid,
   input  wire logic         arready,
   input  wire logic [31:0]  rdata,
   input  wire logic [1:0]   rresp,
   input  wire logic         rvalid,
   output logic              rready
);
   initial begin
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
      rready = 1'b0;
   end
   // Released payload is inverted so stale values never look valid
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic a_ok;
      logic w_ok;
      logic b_ok;
      @(posedge mclk);
      awaddr <= {2'b00, idx, 2'b00};
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wvalid <= 1'b1;
      b_ok = 1'b0;
      while (!b_ok) begin
         @(posedge mclk);
         a_ok = awvalid && awready;
         w_ok = wvalid && wready;
         b_ok = bvalid && bready;
         if (a_ok) begin
            awvalid <= 1'b0;
            awaddr <= ~awaddr;
         end
         if (w_ok) begin
            wvalid <= 1'b0;
            wdata <= ~wdata;
         end
         bready <= bvalid && !b_ok;
      end
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                     output logic [1:0] r);
      logic a_ok;
      logic ok;
      @(posedge mclk);
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      ok = 1'b0;
      while (!ok) begin
         @(posedge mclk);
         a_ok = arvalid && arready;
         ok = rvalid && rready;
         d = rdata;
         r = rresp;
         if (a_ok) begin
            arvalid <= 1'b0;
            araddr <= ~araddr;
         end
         rready <= rvalid && !ok;
      end
   endtask
endmodule

/* File: mac_pkg.sv */
// Constants and carrier types for the alert mask and config register bank
package mac_pkg;
   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 8;
   localparam int GRP_N = 2;
   localparam int CH_N = 4;
   localparam int MEAS_W = 10;
   localparam int PIN_N = 2;

   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_MASK_ONE = 8'h74;
   localparam logic [7:0] IDX_MASK_TWO = 8'h75;
   localparam logic [7:0] IDX_LOW_VOLT = 8'h76;
   localparam logic [7:0] IDX_LOW_MIX = 8'h77;
   localparam logic [7:0] IDX_CFG3 = 8'h78;
   localparam logic [7:0] IDX_OT_STAT = 8'h79;
   localparam logic [7:0] IDX_CFG4 = 8'h7D;
   localparam logic [7:0] IDX_LOCK = 8'h7C;
   localparam logic [7:0] IDX_HIGH_BASE = 8'h60;
   localparam logic [7:0] IDX_HIGH_LAST = 8'h67;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] PEND_ALL = 4'hF;
   localparam logic [3:0] PEND_NONE = 4'h0;

   // Field positions
   localparam int MASK1_STAT2 = 7;
   localparam logic [7:0] MASK2_WR = 8'hFD;
   localparam int MASK2_FAN4 = 5;
   localparam int CFG3_ALERT = 0;
   localparam int CFG3_OT_EN = 1;
   localparam int CFG3_FAN_FULL_SPEED_ON_OVERTEMP = 2;
   localparam int CFG3_FAST = 3;
   localparam int CFG3_CONT = 4;
   localparam int CFG4_PIN_SEL = 1;
   localparam int LOCK_BIT = 0;
   localparam int PIN_5V = 0;
   localparam int PIN_TACH4 = 1;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Overtemp timer resolution
   localparam int TICK_US = 22760;
   localparam int CLK_NS = 10;
   localparam int TICK_CYCLES = TICK_US * 1000 / CLK_NS;
   localparam logic [7:0] TMR_MAX = 8'hFF;

   // One group of four 10-bit readings, channel 0 in the low pair
   typedef struct packed {
      logic [CH_N-1:0][MEAS_W-1:0] val;
   } mac_group_s;

   // Live status conditions from the measurement engine
   typedef struct packed {
      logic [7:0] two;
      logic [6:0] one;
   } mac_status_s;
endpackage

/* File: mac_regs.sv */
// Alert mask, extended resolution and third config register bank
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Mask one bits 0-6 block alert for the seven voltage/temp channels.
// - Mask one bit 7 blocks alert for every second-status condition.
// - Mask two bit 0 blocks alert for the 12 V channel.
// - Mask two bit 1 stays zero and never masks overtemp events; host writes leave it alone.
// - Mask two bits 2-4 block alert for fan 1, 2, 3 faults.
// - Mask two bit 5 masks fan 4 fault, or timer event in tach4 overtemp use.
// - Mask two bits 6-7 block alert for diode faults on remote 1, 2.
// - Both mask registers reset to all zeros.
// - Low-bit register one packs 2.5 V, core, supply, 5 V low pairs.
// - Low-bit register two packs 12 V, remote 1, local, remote 2 pairs.
// - Reading a low-bit register freezes it and its high bytes until read.
// - Config three bit 0 turns the shared pin into the alert output.
// - Config three bit 1 enables overtemp monitoring on the selected pin.
// - Timer measures how long an enabled overtemp input stays asserted.
// - Fan_full_speed_on_overtemp bit forces all fans to full duty during overtemp.
// - Fast bit raises fan_speed_input rate from once a second to every 250 ms.
// - Config three bits 4-7 make fan_speed_input inputs 1-4 measure continuously.
// - Config three resets to zero and ignores writes once locked.
// - Pin select 1 picks the 5 V pin as overtemp input, else tach 4.
// - Overtemp status flag sets on assertion and clears when read.
module mac_regs
   import mac_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input  wire logic                 mclk,
   input  wire logic                 resetn,
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire mac_group_s           meas_volt,
   input  wire mac_group_s           meas_mix,
   input  wire mac_status_s          status_in,
   input  wire logic                 fan_four_fault,
   input  wire logic                 overtemp_timer_event,
   input  wire logic                 overtemp_input_5v,
   input  wire logic                 overtemp_input_tach4,
   output logic                      alert_out,
   output logic                      alert_pin_mode,
   output logic                      overtemp_monitor_en,
   output logic                      overtemp_active,
   output logic                      fans_full_speed,
   output logic                      fast_fan_speed_input_rate,
   output logic [3:0]                continuous_speed,
   output logic                      overtemp_pin_select,
   output logic [7:0]                overtemp_timer
);

   // Packs the two low bits of each reading of a group
   function automatic logic [7:0] low_pairs(input mac_group_s g);
      logic [7:0] r;
      r = RST_BYTE;
      for (int k = 0; k < CH_N; k++) begin
         r[2*k +: 2] = g.val[k][1:0];
      end
      return r;
   endfunction

   // High byte of one reading
   function automatic logic [7:0] high_byte(input logic [9:0] v);
      return v[MEAS_W-1:2];
   endfunction

   // Word index of a byte address
   function automatic logic [IDX_W-1:0] to_idx(
      input logic [ADDR_W-1:0] a);
      return a[IDX_LSB +: IDX_W];
   endfunction

   logic [7:0]        mask_one_q;
   logic [7:0]        mask_two_q;
   logic [7:0]        cfg3_q;
   logic [7:0]        cfg4_q;
   logic              lock_q;
   mac_group_s        held_q [GRP_N];
   logic [3:0]        pend_q [GRP_N];
   logic              aw_held_q;
   logic              w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0]        wbyte_q;
   logic              wen_q;
   logic              bvalid_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   logic [PIN_N-1:0]  s1_q;
   logic [PIN_N-1:0]  s2_q;
   logic [PIN_N-1:0]  s3_q;
   logic [PIN_N-1:0]  pin_q;
   logic              ot_prev_q;
   logic              ot_flag_q;
   logic [31:0]       tick_q;
   logic [7:0]        tmr_q;
   logic              alert_q;

   // Bus handshakes
   wire do_wr = aw_held_q & w_held_q & ~bvalid_q;
   wire rd_go = s_axi_arvalid & ~rvalid_q;
   wire [IDX_W-1:0] wr_idx = to_idx(awaddr_q);
   wire [IDX_W-1:0] rd_idx = to_idx(s_axi_araddr);
   wire wr_ok = do_wr & wen_q;

   assign s_axi_awready = ~aw_held_q;
   assign s_axi_wready  = ~w_held_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = RESP_OKAY;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // Read side-effect strobes
   wire rd_low_volt = rd_go & (rd_idx == IDX_LOW_VOLT);
   wire rd_low_mix  = rd_go & (rd_idx == IDX_LOW_MIX);
   wire rd_ot_stat  = rd_go & (rd_idx == IDX_OT_STAT);
   wire rd_high = rd_go & (rd_idx >= IDX_HIGH_BASE)
                  & (rd_idx <= IDX_HIGH_LAST);
   wire [IDX_W-1:0] hi_off = rd_idx - IDX_HIGH_BASE;
   wire hi_grp = hi_off[2];
   wire [1:0] hi_ch = hi_off[1:0];

   // Freeze flag of each group, set while any of its high bytes is unread
   wire frz_volt = |pend_q[0];
   wire frz_mix  = |pend_q[1];

   // Overtemp source selection and qualification
   wire ot_raw = cfg4_q[CFG4_PIN_SEL] ? pin_q[PIN_5V]
                                       : pin_q[PIN_TACH4];
   wire ot_act = cfg3_q[CFG3_OT_EN] & ot_raw;
   wire ot_rise = ot_act & ~ot_prev_q;
   wire tick_end = (tick_q == 32'(TICK_CYC - 1));

   // Second status with fan 4 slot rerouted in tach4 overtemp use
   wire tach4_ot = cfg3_q[CFG3_OT_EN] & ~cfg4_q[CFG4_PIN_SEL];
   wire slot5 = tach4_ot ? overtemp_timer_event
                         : fan_four_fault;
   wire [7:0] st_two;
   assign st_two = {status_in.two[7:6], slot5,
                    status_in.two[4:0]};

   // Alert qualification
   wire hit_one = |(status_in.one & ~mask_one_q[6:0]);
   wire hit_two = ~mask_one_q[MASK1_STAT2]
                  & |(st_two & ~mask_two_q);
   wire alert_d = cfg3_q[CFG3_ALERT] & (hit_one | hit_two);

   // Read data selection
   logic [7:0] rd_byte;
   logic       rd_hit;
   always_comb begin
      rd_byte = RST_BYTE;
      rd_hit  = 1'b1;
      if (rd_idx == IDX_MASK_ONE) begin
         rd_byte = mask_one_q;
      end else if (rd_idx == IDX_MASK_TWO) begin
         rd_byte = mask_two_q;
      end else if (rd_idx == IDX_LOW_VOLT) begin
         rd_byte = low_pairs(held_q[0]);
      end else if (rd_idx == IDX_LOW_MIX) begin
         rd_byte = low_pairs(held_q[1]);
      end else if (rd_idx == IDX_CFG3) begin
         rd_byte = cfg3_q;
      end else if (rd_idx == IDX_OT_STAT) begin
         rd_byte = {tmr_q[7:1], tmr_q[0] | ot_flag_q};
      end else if (rd_idx == IDX_CFG4) begin
         rd_byte = cfg4_q;
      end else if (rd_idx == IDX_LOCK) begin
         rd_byte = {7'h00, lock_q};
      end else if (rd_high) begin
         rd_byte = high_byte(held_q[hi_grp].val[hi_ch]);
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Write address and data capture, either order
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && !aw_held_q) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         w_held_q <= 1'b0;
         wbyte_q  <= RST_BYTE;
         wen_q    <= 1'b0;
      end else if (s_axi_wvalid && !w_held_q) begin
         w_held_q <= 1'b1;
         wbyte_q  <= s_axi_wdata[7:0];
         wen_q    <= s_axi_wstrb[0];
      end else if (do_wr) begin
         w_held_q <= 1'b0;
      end
   end

   // Write response
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         bvalid_q <= 1'b0;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read answer
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h000000, rd_byte};
         rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Mask registers
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         mask_one_q <= RST_BYTE;
         mask_two_q <= RST_BYTE;
      end else if (wr_ok && wr_idx == IDX_MASK_ONE) begin
         mask_one_q <= wbyte_q;
      end else if (wr_ok && wr_idx == IDX_MASK_TWO) begin
         mask_two_q <= (wbyte_q & MASK2_WR)
                       | (mask_two_q & ~MASK2_WR);
      end
   end

   // Lockable configuration
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cfg3_q <= RST_BYTE;
         cfg4_q <= RST_BYTE;
         lock_q <= 1'b0;
      end else if (wr_ok && !lock_q && wr_idx == IDX_CFG3) begin
         cfg3_q <= wbyte_q;
      end else if (wr_ok && !lock_q && wr_idx == IDX_CFG4) begin
         cfg4_q <= wbyte_q;
      end else if (wr_ok && wr_idx == IDX_LOCK) begin
         lock_q <= lock_q | wbyte_q[LOCK_BIT];
      end
   end

   // Coherent capture of readings
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         held_q[0] <= '0;
         held_q[1] <= '0;
      end else begin
         if (!frz_volt && !rd_low_volt) begin
            held_q[0] <= meas_volt;
         end
         if (!frz_mix && !rd_low_mix) begin
            held_q[1] <= meas_mix;
         end
      end
   end

   // Freeze bookkeeping, one pending bit per high byte
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pend_q[0] <= PEND_NONE;
         pend_q[1] <= PEND_NONE;
      end else if (rd_low_volt) begin
         pend_q[0] <= PEND_ALL;
      end else if (rd_low_mix) begin
         pend_q[1] <= PEND_ALL;
      end else if (rd_high) begin
         pend_q[hi_grp][hi_ch] <= 1'b0;
      end
   end

   // Overtemp pin synchronisers, change taken when stages 2 and 3 agree
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         pin_q <= '0;
      end else begin
         s1_q  <= {overtemp_input_tach4, overtemp_input_5v};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
      end
   end

   // Overtemp flag, set wins over clear on read
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ot_prev_q <= 1'b0;
         ot_flag_q <= 1'b0;
      end else begin
         ot_prev_q <= ot_act;
         ot_flag_q <= ot_rise | (ot_flag_q & ~rd_ot_stat);
      end
   end

   // Assertion duration timer
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         tick_q <= '0;
         tmr_q  <= RST_BYTE;
      end else if (ot_rise) begin
         tick_q <= '0;
         tmr_q  <= RST_BYTE;
      end else if (ot_act) begin
         tick_q <= tick_end ? '0 : tick_q + 32'd1;
         if (tick_end && tmr_q != TMR_MAX) begin
            tmr_q <= tmr_q + 8'h01;
         end
      end
   end

   // Registered alert
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= alert_d;
      end
   end

   // Fan and fan_speed_input controls
   logic fan_full_speed_on_overtemp_q;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         fan_full_speed_on_overtemp_q <= 1'b0;
      end else begin
         fan_full_speed_on_overtemp_q <= cfg3_q[CFG3_FAN_FULL_SPEED_ON_OVERTEMP] & ot_act;
      end
   end

   assign alert_out           = alert_q;
   assign alert_pin_mode      = cfg3_q[CFG3_ALERT];
   assign overtemp_monitor_en = cfg3_q[CFG3_OT_EN];
   assign overtemp_active     = ot_prev_q;
   assign fans_full_speed     = fan_full_speed_on_overtemp_q;
   assign fast_fan_speed_input_rate      = cfg3_q[CFG3_FAST];
   assign continuous_speed    = cfg3_q[CFG3_CONT +: 4];
   assign overtemp_pin_select = cfg4_q[CFG4_PIN_SEL];
   assign overtemp_timer      = tmr_q;

endmodule

/* File: mac_regs_sva.sv */
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
module mac_regs_sva
   import mac_pkg::*;
(
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire mac_status_s status_in,
   input wire logic        fan_four_fault,
   input wire logic        overtemp_timer_event,
   input wire logic        alert_out,
   input wire logic        alert_pin_mode,
   input wire logic [3:0]  continuous_speed
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write answer dropped");
   a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY)
      else $error("write response not okay");
   a_reset_quiet: assert property (disable iff (1'b0) !resetn
      |=> !alert_out && !alert_pin_mode && continuous_speed == 4'h0)
      else $error("outputs not cleared by reset");
   a_alert_gated: assert property (!alert_pin_mode |=> !alert_out)
      else $error("alert without pin mode");
   a_alert_cause: assert property (alert_out |->
      $past(status_in != '0 || fan_four_fault || overtemp_timer_event))
      else $error("alert without a condition");
endmodule

/* File: test_monitor_alert_mask_config_regs.sv */
// Self-checking bench for the alert mask and config register bank
`timescale 1ns/1ps
module test_monitor_alert_mask_config_regs;
   import mac_pkg::*;
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] wd;
      logic [7:0] rd;
   } mac_row_s;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic        mclk = 1'b0, resetn = 1'b0, awready, wready, bvalid;
   logic        awvalid, wvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [39:0] mv = '0, mx = '0;
   logic [14:0] st = '0;
   logic        f4 = 1'b0, ot5 = 1'b0, ot4 = 1'b0, alert, pin_mode, ot_en;
   logic        ot_act, full, fast, sel, te = 1'b0;
   logic [3:0]  cont;
   logic [7:0]  tmr;
   int          fail_count = 0, tests_run = 0, cyc = 0;
   mac_row_s    rows [10] = '{
      '{IDX_MASK_ONE, 8'hA5, 8'hA5}, '{IDX_MASK_TWO, 8'hFF, 8'hFD},
      '{IDX_MASK_TWO, 8'h00, 8'h00}, '{IDX_MASK_ONE, 8'h00, 8'h00},
      '{IDX_CFG3, 8'h01, 8'h01}, '{IDX_CFG3, 8'h0A, 8'h0A},
      '{IDX_CFG3, 8'hF0, 8'hF0}, '{IDX_CFG3, 8'h50, 8'h50},
      '{IDX_CFG3, 8'h00, 8'h00}, '{IDX_LOW_VOLT, 8'hFF, 8'h00}};
   always #5 mclk = ~mclk;
   mac_host_model host (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   mac_regs #(.TICK_CYC(1000)) DUT (.mclk(mclk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .meas_volt(mv),
      .meas_mix(mx), .status_in(st), .fan_four_fault(f4),
      .overtemp_timer_event(te), .overtemp_input_5v(ot5),
      .overtemp_input_tach4(ot4), .alert_out(alert), .alert_pin_mode(pin_mode),
      .overtemp_monitor_en(ot_en), .overtemp_active(ot_act),
      .fans_full_speed(full), .fast_fan_speed_input_rate(fast), .continuous_speed(cont),
      .overtemp_pin_select(sel), .overtemp_timer(tmr));
   function automatic logic [7:0] lowb(input logic [39:0] v);
      return {v[31:30], v[21:20], v[11:10], v[1:0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      host.rd(idx, d, r);
      chk($sformatf("reg %h", idx), {24'h0, e}, d);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      wait_n(5);
      resetn <= 1'b1;
      foreach (rows[i]) rchk(rows[i].idx, 8'h00);
      foreach (rows[i]) begin
         host.wr(rows[i].idx, rows[i].wd);
         rchk(rows[i].idx, rows[i].rd);
         if (rows[i].idx == IDX_CFG3)
            chk("cfg3 pins", {rows[i].wd[7:3], rows[i].wd[1:0]},
                {cont, fast, ot_en, pin_mode});
      end
      for (int k = 0; k < 4; k++)
         rchk(IDX_HIGH_BASE + 8'(k), 8'h00);
      $display("done: register rows");
      host.wr(IDX_CFG3, 8'h01);
      for (int i = 0; i < 15; i++) begin
         st <= (i == 12) ? 15'h0000 : 15'(1 << i);
         f4 <= (i == 12);
         wait_n(3);
         chk("alert raised", 1, alert);
         if (i < 7) host.wr(IDX_MASK_ONE, 8'(1 << i));
         else host.wr(IDX_MASK_TWO, 8'(1 << (i - 7)));
         wait_n(3);
         chk("alert masked", i == 8, alert);
         host.wr(IDX_MASK_ONE, 8'h00);
         host.wr(IDX_MASK_TWO, 8'h00);
      end
      st <= 15'h7F80;
      f4 <= 1'b0;
      host.wr(IDX_MASK_ONE, 8'h80);
      wait_n(3);
      chk("second status masked", 0, alert);
      st <= 15'h7F81;
      wait_n(3);
      chk("first status kept", 1, alert);
      $display("done: alert masks");
      mv <= {10'h1C6, 10'h2B9, 10'h0F2, 10'h35D};
      wait_n(3);
      rchk(IDX_LOW_VOLT, 8'h99);
      mv <= {10'h2E1, 10'h13A, 10'h3C7, 10'h05E};
      wait_n(3);
      rchk(IDX_LOW_VOLT, 8'h99);
      for (int k = 0; k < 4; k++)
         rchk(IDX_HIGH_BASE + 8'(k), 8'({10'h35D, 10'h0F2, 10'h2B9,
              10'h1C6} >> (10 * (3 - k) + 2)));
      wait_n(3);
      rchk(IDX_LOW_VOLT, lowb(mv));
      mx <= {10'h0A7, 10'h3F0, 10'h162, 10'h29B};
      wait_n(3);
      rchk(IDX_LOW_MIX, lowb({10'h0A7, 10'h3F0, 10'h162, 10'h29B}));
      $display("done: low bits");
      host.wr(IDX_CFG4, 8'h02);
      host.wr(IDX_CFG3, 8'h06);
      chk("pin select", 1, sel);
      ot4 <= 1'b1;
      wait_n(10);
      chk("tach4 ignored", 0, ot_act);
      ot4 <= 1'b0;
      ot5 <= 1'b1;
      wait_n(10);
      chk("overtemp seen", 1, ot_act);
      chk("fans boosted", 1, full);
      rchk(IDX_OT_STAT, 8'h01);
      rchk(IDX_OT_STAT, 8'h00);
      wait_n(2500);
      chk("timer", 8'h02, tmr);
      ot5 <= 1'b0;
      wait_n(10);
      chk("fan_full_speed_on_overtemp off", 0, full);
      st <= '0;
      host.wr(IDX_MASK_ONE, 8'h00);
      host.wr(IDX_CFG4, 8'h00);
      host.wr(IDX_CFG3, 8'h07);
      chk("pin select", 0, sel);
      ot4 <= 1'b1;
      wait_n(10);
      chk("tach4 overtemp", 1, ot_act);
      ot4 <= 1'b0;
      f4 <= 1'b1;
      wait_n(10);
      chk("fan four rerouted", 0, alert);
      te <= 1'b1;
      wait_n(3);
      chk("timer event alert", 1, alert);
      host.wr(IDX_MASK_TWO, 8'h20);
      wait_n(3);
      chk("timer event masked", 0, alert);
      te <= 1'b0;
      f4 <= 1'b0;
      host.wr(IDX_LOCK, 8'h01);
      host.wr(IDX_CFG3, 8'h00);
      rchk(IDX_CFG3, 8'h07);
      host.rd(8'h10, d, r);
      chk("unmapped resp", RESP_SLVERR, r);
      resetn <= 1'b0;
      wait_n(2);
      resetn <= 1'b1;
      rchk(IDX_CFG3, 8'h00);
      rchk(IDX_MASK_ONE, 8'h00);
      $display("done: overtemp and lock");
      wrap_up();
   end
endmodule
bind mac_regs mac_regs_sva u_sva (.mclk(mclk), .resetn(resetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .status_in(status_in), .fan_four_fault(fan_four_fault),
   .overtemp_timer_event(overtemp_timer_event), .alert_out(alert_out),
   .alert_pin_mode(alert_pin_mode), .continuous_speed(continuous_speed));
